// File: core/dpm_dual_port_memory_cell.sv
// Functional notes
// - two ports read or write independently
// - own port controls, any width, whole memory
// - split ports max 20, whole max 40
// - half cell widths 1 to 20
// - whole cell widths 1 to 40
// - mask wired like data; halves alike
// - simple mode: A writes, B reads
// - write needs enable+we, read enable only
// - half simple mode 40 by 512
// - whole simple mode 80 by 512
// - 80-bit only whole simple mode
// - controls may come from neighbour cell
// - cascade forwards 1-bit data and mask down
// - in true dual mode, address bit 0 picks upper or lower
// - 1- and 2-bit words skip every fifth bit
// - write needs enable, write enable, mask
`timescale 1ns/1ps
`default_nettype none
module dpm_dual_port_memory_cell (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // configuration
   input wire logic cfgWholeCell,
   input wire logic cfgSimpleDual,
   input wire dpm_pkg::dpm_width_t [3:0] cfgWidth,
   input wire logic [3:0] cfgOutReg,
   input wire logic cfgForwardCtrl,
   input wire logic cfgCascadeUpper,
   input wire logic cfgCascadeLower,
   // port a lower group
   input wire logic portALowerGroupEnable,
   input wire logic portALowerGroupWriteEnable,
   input wire logic [15:0] portALowerGroupAddress,
   input wire logic [19:0] portALowerGroupWriteData,
   input wire logic [19:0] portALowerGroupBitMask,
   output logic [19:0] portALowerGroupReadData,
   // port a upper group
   input wire logic portAUpperGroupEnable,
   input wire logic portAUpperGroupWriteEnable,
   input wire logic [15:0] portAUpperGroupAddress,
   input wire logic [19:0] portAUpperGroupWriteData,
   input wire logic [19:0] portAUpperGroupBitMask,
   output logic [19:0] portAUpperGroupReadData,
   // port b lower group
   input wire logic portBLowerGroupEnable,
   input wire logic portBLowerGroupWriteEnable,
   input wire logic [15:0] portBLowerGroupAddress,
   input wire logic [19:0] portBLowerGroupWriteData,
   input wire logic [19:0] portBLowerGroupBitMask,
   output logic [19:0] portBLowerGroupReadData,
   // port b upper group
   input wire logic portBUpperGroupEnable,
   input wire logic portBUpperGroupWriteEnable,
   input wire logic [15:0] portBUpperGroupAddress,
   input wire logic [19:0] portBUpperGroupWriteData,
   input wire logic [19:0] portBUpperGroupBitMask,
   output logic [19:0] portBUpperGroupReadData,
   // from the cell above; casInReadData comes from the cell below
   input wire logic [3:0] casInEnable,
   input wire logic [3:0] casInWriteEnable,
   input wire logic [3:0][15:0] casInAddress,
   input wire logic [3:0] casInWriteData,
   input wire logic [3:0] casInBitMask,
   input wire logic [3:0] casInReadData,
   // to the cell below
   output logic [3:0] casOutEnable,
   output logic [3:0] casOutWriteEnable,
   output logic [3:0][15:0] casOutAddress,
   output logic [3:0] casOutWriteData,
   output logic [3:0] casOutBitMask
);

   localparam int unsigned NG = dpm_pkg::DPM_GROUPS;
   localparam int unsigned GW = dpm_pkg::DPM_GRP_W;
   localparam int unsigned RW = dpm_pkg::DPM_ROW_W;
   localparam int unsigned HW = dpm_pkg::DPM_HALF_W;
   localparam int unsigned CS = dpm_pkg::DPM_CAS_STAGES;

   // effective group controls after forwarding
   logic [NG-1:0] ownEn, ownWe, grpEn, grpWe;
   logic [NG-1:0][15:0] ownAddr, grpAddr;
   logic [NG-1:0][GW-1:0] ownDi, ownBm, grpDi, grpBm;
   // access qualification
   logic [NG-1:0] roleOk, accEn, wrAct;
   // per-lane memory view
   dpm_pkg::dpm_width_t [NG-1:0] laneWidth;
   logic [NG-1:0][dpm_pkg::DPM_ROW_AW-1:0] laneRow;
   logic [NG-1:0][RW-1:0] laneRowData, tdpMask, tdpData, wrMask, wrData;
   logic [NG-1:0][HW-1:0] laneWd, laneBm, laneRd;
   // output capture per group
   logic [NG-1:0] rawCap, outCap;
   logic [NG-1:0][GW-1:0] rawData, outData, grpDo;
   // cascade forwarding and return pipe
   logic [NG-1:0] casEn_q, casEn_d, casWe_q, casWe_d, casDi_q, casDi_d, casBm_q, casBm_d;
   logic [NG-1:0][15:0] casAddr_q, casAddr_d;
   logic [NG-1:0][CS-1:0] pipeCap_q, pipeCap_d, pipeSel_q, pipeSel_d, pipeBit_q, pipeBit_d;

   // the array: 512 rows of four 20-bit blocks, no reset like a real sram
   logic [RW-1:0] memArray [dpm_pkg::DPM_ROWS];

   // pack the four signal groups: 0 a-lower, 1 a-upper, 2 b-lower, 3 b-upper
   assign ownEn = {portBUpperGroupEnable, portBLowerGroupEnable, portAUpperGroupEnable,
                   portALowerGroupEnable};
   assign ownWe = {portBUpperGroupWriteEnable, portBLowerGroupWriteEnable,
                   portAUpperGroupWriteEnable, portALowerGroupWriteEnable};
   assign ownAddr = {portBUpperGroupAddress, portBLowerGroupAddress, portAUpperGroupAddress,
                     portALowerGroupAddress};
   assign ownDi = {portBUpperGroupWriteData, portBLowerGroupWriteData,
                   portAUpperGroupWriteData, portALowerGroupWriteData};
   assign ownBm = {portBUpperGroupBitMask, portBLowerGroupBitMask, portAUpperGroupBitMask,
                   portALowerGroupBitMask};

   // input selection, qualification and lane setup
   always_comb begin
      for (int g = 0; g < NG; g++) begin
         grpEn[g] = cfgForwardCtrl ? casInEnable[g] : ownEn[g];
         grpWe[g] = cfgForwardCtrl ? casInWriteEnable[g] : ownWe[g];
         grpAddr[g] = cfgForwardCtrl ? casInAddress[g] : ownAddr[g];
         // 1-bit data and mask from above
         grpDi[g] = cfgCascadeLower ? {{(GW-1){1'b0}}, casInWriteData[g]} : ownDi[g];
         grpBm[g] = cfgCascadeLower ? {{(GW-1){1'b0}}, casInBitMask[g]} : ownBm[g];
         if (cfgCascadeUpper) begin
            accEn[g] = grpEn[g] & ~grpAddr[g][0];
         end else if (cfgCascadeLower) begin
            accEn[g] = grpEn[g] & grpAddr[g][0];
         end else begin
            accEn[g] = grpEn[g];
         end
         // whole cell: groups 0 and 2 steer ports a and b
         roleOk[g] = cfgWholeCell ? (g % 2 == 0) : 1'b1;
         // a split port stops at 20 bits
         laneWidth[g] = cfgWidth[g];
         if (!cfgWholeCell && cfgWidth[g] == dpm_pkg::DPM_W40) begin
            laneWidth[g] = dpm_pkg::DPM_W20;
         end
         laneRow[g] = grpAddr[g][15:dpm_pkg::DPM_ROW_LSB];
         laneRowData[g] = memArray[laneRow[g]];
         // 40-bit word is upper group above lower group
         // mask wired like data, halves alike
         if (cfgWholeCell) begin
            laneWd[g] = {grpDi[g | 1], grpDi[g]};
            laneBm[g] = {grpBm[g | 1], grpBm[g]};
         end else begin
            laneWd[g] = {{GW{1'b0}}, grpDi[g]};
            laneBm[g] = {{GW{1'b0}}, grpBm[g]};
         end
      end
   end

   for (genvar g = 0; g < NG; g++) begin : gLane
      localparam logic HALF = 1'(g % 2);
      dpm_lane_map uMap (
         .widthCode(laneWidth[g]),
         .wholeCell(cfgWholeCell),
         .halfSel(HALF),
         .addrLow(grpAddr[g][dpm_pkg::DPM_SLOT_W-1:0]),
         .wrData(laneWd[g]),
         .wrMask(laneBm[g]),
         .rowData(laneRowData[g]),
         .colMask(tdpMask[g]),
         .colData(tdpData[g]),
         .rdData(laneRd[g])
      );
   end

   // write planning for both port modes
   always_comb begin
      for (int g = 0; g < NG; g++) begin
         wrMask[g] = '0;
         wrData[g] = '0;
         wrAct[g] = 1'b0;
         if (cfgSimpleDual) begin
            if (g < 2) begin
               // write port needs enable and write enable
               wrAct[g] = roleOk[g] & grpEn[g] & grpWe[g];
               // blocks stack b-upper, b-lower, a-upper, a-lower
               for (int k = 0; k < NG; k++) begin
                  if (cfgWholeCell || (k % 2 == g % 2)) begin
                     wrMask[g][k*GW +: GW] = grpBm[k];
                     wrData[g][k*GW +: GW] = grpDi[k];
                  end
               end
            end
         end else begin
            // every tdp port may write on its own
            wrAct[g] = roleOk[g] & accEn[g] & grpWe[g];
            wrMask[g] = tdpMask[g];
            wrData[g] = tdpData[g];
         end
      end
   end

   // a bit changes only under enable, write enable and its mask
   // same-address writes from two lanes resolve by lane order, undefined for users
   always_ff @(posedge sys_clk) begin
      for (int g = 0; g < NG; g++) begin
         if (wrAct[g]) begin
            for (int c = 0; c < RW; c++) begin
               if (wrMask[g][c]) begin
                  memArray[laneRow[g]][c] <= wrData[g][c];
               end
            end
         end
      end
   end

   // read capture and cascade return pipe
   always_comb begin
      int unsigned src;
      src = 0;
      for (int k = 0; k < NG; k++) begin
         if (cfgSimpleDual) begin
            // read port b needs only its enable
            src = cfgWholeCell ? 2 : 2 + k % 2;
            rawData[k] = laneRowData[src][k*GW +: GW];
            rawCap[k] = roleOk[src] & grpEn[src];
         end else begin
            // writes leave the output at the last read word
            src = cfgWholeCell ? k - k % 2 : k;
            rawData[k] = (cfgWholeCell && k % 2 == 1) ? laneRd[src][HW-1:GW] : laneRd[src][GW-1:0];
            rawCap[k] = roleOk[src] & accEn[src] & ~grpWe[src];
         end
         // own bit waits for the lower cell's round trip
         pipeCap_d[k] = {pipeCap_q[k][CS-2:0], grpEn[k] & ~grpWe[k]};
         pipeSel_d[k] = {pipeSel_q[k][CS-2:0], grpAddr[k][0]};
         pipeBit_d[k] = {pipeBit_q[k][CS-2:0], rawData[k][0]};
         if (cfgCascadeUpper) begin
            outCap[k] = pipeCap_q[k][CS-1];
            outData[k] = {{(GW-1){1'b0}},
                          pipeSel_q[k][CS-1] ? casInReadData[k] : pipeBit_q[k][CS-1]};
         end else begin
            outCap[k] = rawCap[k];
            outData[k] = rawData[k];
         end
      end
      // controls leave registered toward the cell below
      casEn_d = grpEn;
      casWe_d = grpWe;
      casAddr_d = grpAddr;
      casDi_d = '0;
      casBm_d = '0;
      for (int k = 0; k < NG; k++) begin
         casDi_d[k] = grpDi[k][0];
         casBm_d[k] = grpBm[k][0];
      end
   end

   // cascade and pipe registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         casEn_q <= '0;
         casWe_q <= '0;
         casAddr_q <= '0;
         casDi_q <= '0;
         casBm_q <= '0;
         pipeCap_q <= '0;
         pipeSel_q <= '0;
         pipeBit_q <= '0;
      end else begin
         casEn_q <= casEn_d;
         casWe_q <= casWe_d;
         casAddr_q <= casAddr_d;
         casDi_q <= casDi_d;
         casBm_q <= casBm_d;
         pipeCap_q <= pipeCap_d;
         pipeSel_q <= pipeSel_d;
         pipeBit_q <= pipeBit_d;
      end
   end

   // one clock latency, plus one with the output register
   for (genvar k = 0; k < NG; k++) begin : gOut
      dpm_out_stage uOut (
         .sys_clk(sys_clk),
         .nrst(nrst),
         .capture(outCap[k]),
         .capData(outData[k]),
         .outRegEn(cfgOutReg[k]),
         .dataOut(grpDo[k])
      );
   end

   assign portALowerGroupReadData = grpDo[0];
   assign portAUpperGroupReadData = grpDo[1];
   assign portBLowerGroupReadData = grpDo[2];
   assign portBUpperGroupReadData = grpDo[3];
   assign casOutEnable = casEn_q;
   assign casOutWriteEnable = casWe_q;
   assign casOutAddress = casAddr_q;
   assign casOutWriteData = casDi_q;
   assign casOutBitMask = casBm_q;

   // checks on the design's own behaviour
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence sqReadNoReg;
      outCap[0] && !cfgOutReg[0];
   endsequence
   sequence sqReadWithReg;
      outCap[0] && cfgOutReg[0] ##1 cfgOutReg[0];
   endsequence
   sequence sqLowerRead;
      cfgCascadeUpper && !cfgOutReg[0] && grpEn[0] && !grpWe[0] && grpAddr[0][0];
   endsequence

   AST_READ_ONE_CLOCK: assert property (sqReadNoReg |=> grpDo[0] == $past(outData[0]))
      else $error("read data not on output one clock after capture");
   AST_READ_OUT_REG: assert property (sqReadWithReg |=> grpDo[0] == $past(outData[0], 2))
      else $error("registered read data not two clocks after capture");
   AST_WRITE_HOLDS_OUT: assert property (!outCap[0] && !cfgOutReg[0] ##1 !cfgOutReg[0]
         |-> $stable(grpDo[0]))
      else $error("output moved without a read");
   AST_MASKED_WRITE: assert property (wrAct[0] && wrAct[3:1] == '0
         |=> (memArray[$past(laneRow[0])] & $past(wrMask[0]))
             == ($past(wrData[0]) & $past(wrMask[0])))
      else $error("masked bits not written");
   AST_UNMASKED_KEPT: assert property (wrAct[0] && wrAct[3:1] == '0
         |=> (memArray[$past(laneRow[0])] & ~$past(wrMask[0]))
             == ($past(laneRowData[0]) & ~$past(wrMask[0])))
      else $error("bits outside the mask changed");
   AST_SDP_B_NEVER_WRITES: assert property (cfgSimpleDual |-> wrAct[3:2] == '0)
      else $error("read port wrote in simple mode");
   AST_NO_WRITE_WITHOUT_WE: assert property (!grpWe[0] || !grpEn[0] |-> !wrAct[0])
      else $error("write without enable and write enable");
   AST_CASCADE_SELECT: assert property (cfgCascadeUpper && grpAddr[0][0] |-> !wrAct[0])
      else $error("upper cell wrote a lower-cell address");
   AST_FORWARD_CTRL: assert property (1'b1 |=> casOutAddress[0] == $past(grpAddr[0])
         && casOutEnable[0] == $past(grpEn[0]))
      else $error("controls not forwarded one clock later");
   AST_CASCADE_RETURN: assert property (sqLowerRead ##1 !cfgOutReg[0] [*2]
         |=> grpDo[0][0] == $past(casInReadData[0]))
      else $error("lower cell data not returned after three clocks");
   AST_SPLIT_WIDTH: assert property (!cfgWholeCell |-> laneWidth[0] != dpm_pkg::DPM_W40)
      else $error("split port wider than 20 bits");

endmodule
`default_nettype wire

// File: core/dpm_lane_map.sv
`timescale 1ns/1ps
`default_nettype none
// scatters one port word into the 80 physical columns of a row and gathers it back
module dpm_lane_map (
   // word shape
   input wire dpm_pkg::dpm_width_t widthCode,
   input wire logic wholeCell,
   input wire logic halfSel,
   input wire logic [dpm_pkg::DPM_SLOT_W-1:0] addrLow,
   // write side
   input wire logic [dpm_pkg::DPM_HALF_W-1:0] wrData,
   input wire logic [dpm_pkg::DPM_HALF_W-1:0] wrMask,
   // row side: stored row in, write columns and read word out
   input wire logic [dpm_pkg::DPM_ROW_W-1:0] rowData,
   output logic [dpm_pkg::DPM_ROW_W-1:0] colMask,
   output logic [dpm_pkg::DPM_ROW_W-1:0] colData,
   output logic [dpm_pkg::DPM_HALF_W-1:0] rdData
);

   // physical column of word bit bitIdx in word slot
   function automatic logic [dpm_pkg::DPM_SLOT_W-1:0] mapCol(input int unsigned bitIdx,
         input int unsigned slot, input dpm_pkg::dpm_width_t wc, input logic whole,
         input logic half);
      int unsigned pos;
      pos = 0;
      unique case (wc)
         // four usable bits per five-bit segment
         dpm_pkg::DPM_W1: pos = (slot / (dpm_pkg::DPM_SEG_W - 1)) * dpm_pkg::DPM_SEG_W
               + slot % (dpm_pkg::DPM_SEG_W - 1);
         // two 2-bit words per segment, fifth bit left idle
         dpm_pkg::DPM_W2: pos = (slot / dpm_pkg::DPM_W2_PER_SEG) * dpm_pkg::DPM_SEG_W
               + (slot % dpm_pkg::DPM_W2_PER_SEG) * dpm_pkg::dpm_bits(wc) + bitIdx;
         default: pos = slot * dpm_pkg::dpm_bits(wc) + bitIdx;
      endcase
      // a half cell owns block "half" and block "half + 2"
      if (!whole) begin
         pos = (pos < dpm_pkg::DPM_GRP_W) ? pos : pos + dpm_pkg::DPM_GRP_W;
         pos = pos + (half ? dpm_pkg::DPM_GRP_W : 0);
      end
      return pos[dpm_pkg::DPM_SLOT_W-1:0];
   endfunction

   // per-bit scatter and gather
   always_comb begin
      int unsigned w;
      int unsigned slot;
      logic [dpm_pkg::DPM_SLOT_W-1:0] col;
      w = dpm_pkg::dpm_bits(widthCode);
      slot = 0;
      col = '0;
      colMask = '0;
      colData = '0;
      rdData = '0;
      // a half cell ignores addr[6]
      if (wholeCell) begin
         slot = int'(addrLow) >> dpm_pkg::dpm_lsb(widthCode);
      end else begin
         slot = int'(addrLow[dpm_pkg::DPM_HALF_SLOT-1:0]) >> dpm_pkg::dpm_lsb(widthCode);
      end
      for (int i = 0; i < dpm_pkg::DPM_HALF_W; i++) begin
         col = mapCol(i, slot, widthCode, wholeCell, halfSel);
         if (i < w) begin
            colMask[col] = wrMask[i];
            colData[col] = wrData[i];
            rdData[i] = rowData[col];
         end
      end
   end

endmodule
`default_nettype wire

// File: core/dpm_out_stage.sv
`timescale 1ns/1ps
`default_nettype none
// read data latch of one group with the optional extra output register
module dpm_out_stage (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // captured read word and output register enable
   input wire logic capture,
   input wire logic [dpm_pkg::DPM_GRP_W-1:0] capData,
   input wire logic outRegEn,
   // group output
   output logic [dpm_pkg::DPM_GRP_W-1:0] dataOut
);

   logic [dpm_pkg::DPM_GRP_W-1:0] firstStage_q, firstStage_d; // last read word
   logic [dpm_pkg::DPM_GRP_W-1:0] outStage_q, outStage_d;     // what the pin shows

   // holding the last read keeps the output still during writes
   always_comb begin
      firstStage_d = capture ? capData : firstStage_q;
      // with the output register the pin trails the first stage by a clock
      outStage_d = outRegEn ? firstStage_q : firstStage_d;
   end

   // plain registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         firstStage_q <= '0;
         outStage_q <= '0;
      end else begin
         firstStage_q <= firstStage_d;
         outStage_q <= outStage_d;
      end
   end

   assign dataOut = outStage_q;

endmodule
`default_nettype wire

// File: core/dpm_pkg.sv
package dpm_pkg;

   // geometry of one memory cell
   localparam int unsigned DPM_GROUPS = 4;     // a0, a1, b0, b1 signal groups
   localparam int unsigned DPM_GRP_W = 20;     // data / mask width of one group
   localparam int unsigned DPM_ADDR_W = 16;    // address width of one group
   localparam int unsigned DPM_HALF_W = 40;    // widest word of one true dual port
   localparam int unsigned DPM_ROW_W = 80;     // four 20-bit sram blocks side by side
   localparam int unsigned DPM_ROWS = 512;     // rows of the physical array
   localparam int unsigned DPM_ROW_AW = 9;     // row index width
   localparam int unsigned DPM_ROW_LSB = 7;    // row index is addr[15:7]
   localparam int unsigned DPM_SLOT_W = 7;     // addr[6:0] picks the word inside a row
   localparam int unsigned DPM_HALF_SLOT = 6;  // a half cell only sees addr[5:0]
   localparam int unsigned DPM_SEG_W = 5;      // 1- and 2-bit words skip the fifth bit of a segment
   localparam int unsigned DPM_W2_PER_SEG = 2; // 2-bit words per segment
   localparam int unsigned DPM_CAS_STAGES = 2; // cascade round trip seen by the upper cell

   // word width selection of one port
   typedef enum logic [2:0] {DPM_W1, DPM_W2, DPM_W5, DPM_W10, DPM_W20, DPM_W40} dpm_width_t;

   // number of data bits of a width code
   function automatic int unsigned dpm_bits(input dpm_width_t wc);
      int unsigned n;
      n = 1;
      unique case (wc)
         DPM_W1: n = 1;
         DPM_W2: n = 2;
         DPM_W5: n = 5;
         DPM_W10: n = 10;
         DPM_W20: n = 20;
         DPM_W40: n = 40;
         default: n = 1;
      endcase
      return n;
   endfunction

   // lowest address bit that takes part in word selection
   function automatic int unsigned dpm_lsb(input dpm_width_t wc);
      return int'(wc) + 1;
   endfunction

endpackage

// File: sim/dpm_fabric_user.sv
`timescale 1ns/1ps
`default_nettype none
// fabric logic feeding the four signal groups
module dpm_fabric_user (
   // clock
   input wire logic sys_clk,
   // requests, index 0 a-lower, 1 a-upper, 2 b-lower, 3 b-upper
   output logic [3:0] en,
   output logic [3:0] we,
   output logic [3:0][15:0] addr,
   output logic [3:0][19:0] wd,
   output logic [3:0][19:0] bm
);
   // staged request, launched at the next edge
   logic [3:0] sEn = 4'h0;
   logic [3:0] sWe = 4'h0;
   logic [3:0][15:0] sAddr = '0;
   logic [3:0][19:0] sWd = '0;
   logic [3:0][19:0] sBm = '0;
   // idle lines at time zero
   initial begin
      en = 4'h0;
      we = 4'h0;
      addr = '0;
      wd = '0;
      bm = '0;
   end
   // stage group g; callers keep the two ports apart
   // no same-address pairs
   task automatic set(input int g, input logic e, input logic w, input logic [15:0] a,
         input logic [19:0] d, input logic [19:0] m);
      sEn[g] = e;
      sWe[g] = w;
      sAddr[g] = a;
      sWd[g] = d;
      sBm[g] = m;
   endtask
   // launch after the edge, hold one cycle, return at the sampling point
   task automatic go();
      @(posedge sys_clk);
      en <= sEn;
      we <= sWe;
      addr <= sAddr;
      wd <= sWd;
      bm <= sBm;
      sEn = 4'h0;
      sWe = 4'h0;
      // released lines flip so a stale value never looks valid
      sAddr = ~sAddr;
      sWd = ~sWd;
      sBm = ~sBm;
      @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire

// File: sim/tb_dpm_dual_port_memory_cell.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the cell port modes
module tb_dpm_dual_port_memory_cell;
   localparam logic [39:0] D1 = 40'h123456789a;
   localparam logic [39:0] D2 = 40'hfedcba9876;
   localparam logic [39:0] ALL = 40'hffffffffff;
   localparam int BITS[5] = '{1, 2, 5, 10, 20};
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic cfgWholeCell;
   logic cfgSimpleDual;
   dpm_pkg::dpm_width_t [3:0] cfgWidth;
   logic [3:0] cfgOutReg;
   logic [3:0] en, we, cEn, cWe, cWd, cBm;
   logic [3:0][15:0] addr, cAddr;
   logic [3:0][19:0] wd, bm, rd;
   int n_errors = 0;
   int checked = 0;
   int cycleCount = 0;
   // clock, 100 ns period
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   dpm_fabric_user usr (.sys_clk(sys_clk), .en(en), .we(we), .addr(addr), .wd(wd), .bm(bm));
   // cascade kept off: a pair needs both cells at 32K x 1
   // cascade off
   dpm_dual_port_memory_cell DUT (
      .sys_clk(sys_clk), .nrst(nrst), .cfgWholeCell(cfgWholeCell),
      .cfgSimpleDual(cfgSimpleDual), .cfgWidth(cfgWidth), .cfgOutReg(cfgOutReg),
      .cfgForwardCtrl(1'b0), .cfgCascadeUpper(1'b0), .cfgCascadeLower(1'b0),
      .portALowerGroupEnable(en[0]), .portALowerGroupWriteEnable(we[0]),
      .portALowerGroupAddress(addr[0]), .portALowerGroupWriteData(wd[0]),
      .portALowerGroupBitMask(bm[0]), .portALowerGroupReadData(rd[0]),
      .portAUpperGroupEnable(en[1]), .portAUpperGroupWriteEnable(we[1]),
      .portAUpperGroupAddress(addr[1]), .portAUpperGroupWriteData(wd[1]),
      .portAUpperGroupBitMask(bm[1]), .portAUpperGroupReadData(rd[1]),
      .portBLowerGroupEnable(en[2]), .portBLowerGroupWriteEnable(we[2]),
      .portBLowerGroupAddress(addr[2]), .portBLowerGroupWriteData(wd[2]),
      .portBLowerGroupBitMask(bm[2]), .portBLowerGroupReadData(rd[2]),
      .portBUpperGroupEnable(en[3]), .portBUpperGroupWriteEnable(we[3]),
      .portBUpperGroupAddress(addr[3]), .portBUpperGroupWriteData(wd[3]),
      .portBUpperGroupBitMask(bm[3]), .portBUpperGroupReadData(rd[3]),
      .casInEnable(cEn), .casInWriteEnable(cWe), .casInAddress(cAddr),
      .casInWriteData(cWd), .casInBitMask(cBm), .casInReadData(4'h0),
      .casOutEnable(cEn), .casOutWriteEnable(cWe), .casOutAddress(cAddr),
      .casOutWriteData(cWd), .casOutBitMask(cBm));
   // verdict and end of run
   task automatic conclude();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // hang guard
   always @(posedge sys_clk) begin
      cycleCount <= cycleCount + 1;
      if (cycleCount == 400) begin
         n_errors++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // configuration, only changed while idle
   task automatic mode(input logic w, input logic s, input int wc, input logic [3:0] o);
      cfgWholeCell = w;
      cfgSimpleDual = s;
      cfgOutReg = o;
      for (int i = 0; i < 4; i++)
         cfgWidth[i] = dpm_pkg::dpm_width_t'(wc);
   endtask
   // one 40-bit request on a group pair
   task automatic put(input int g, input logic e, input logic w, input logic [15:0] a,
         input logic [39:0] d, input logic [39:0] m);
      usr.set(g, e, w, a, d[19:0], m[19:0]);
      usr.set(g + 1, e, w, a, d[39:20], m[39:20]);
   endtask
   // whole cell: cross-port traffic, masks, output register
   task automatic tdpWhole();
      mode(1'b1, 1'b0, 5, 4'h0);
      // fill rows 0 and 1 from both ports at once so later single writes keep known bits
      put(0, 1'b1, 1'b1, 16'h0000, D2, ALL);
      put(2, 1'b1, 1'b1, 16'h0040, D2, ALL);
      usr.go();
      put(0, 1'b1, 1'b1, 16'h0080, D1, ALL);
      put(2, 1'b1, 1'b1, 16'h00c0, D1, ALL);
      usr.go();
      put(0, 1'b1, 1'b1, 16'h0040, D1, ALL);
      usr.go();
      put(0, 1'b1, 1'b1, 16'h0080, D2, ALL);
      put(2, 1'b1, 1'b0, 16'h0040, 40'h0, 40'h0);
      usr.go();
      put(0, 1'b1, 1'b0, 16'h0080, 40'h0, 40'h0);
      usr.go();
      chk("portB read", {rd[3], rd[2]}, D1);
      put(0, 1'b1, 1'b1, 16'h0040, ~D1, 40'hf);
      put(2, 1'b0, 1'b1, 16'h0080, 40'h0, ALL);
      usr.go();
      chk("portA read", {rd[1], rd[0]}, D2);
      usr.go();
      chk("portA hold", {rd[1], rd[0]}, D2);
      put(2, 1'b1, 1'b0, 16'h0040, 40'h0, 40'h0);
      put(0, 1'b1, 1'b0, 16'h0080, 40'h0, 40'h0);
      repeat (2) usr.go();
      chk("mask write", {rd[3], rd[2]}, D1 ^ 40'hf);
      chk("disabled write", {rd[1], rd[0]}, D2);
      mode(1'b1, 1'b0, 5, 4'hf);
      put(2, 1'b1, 1'b0, 16'h0040, 40'h0, 40'h0);
      usr.go();
      put(2, 1'b1, 1'b0, 16'h0080, 40'h0, 40'h0);
      repeat (2) usr.go();
      chk("outreg first", {rd[3], rd[2]}, D1 ^ 40'hf);
      usr.go();
      chk("outreg second", {rd[3], rd[2]}, D2);
   endtask
   // split cell, every narrow width, both halves at once
   task automatic tdpSplit();
      logic [19:0] m, p0, p1;
      for (int i = 0; i < 5; i++) begin
         mode(1'b0, 1'b0, i, 4'h0);
         m = 20'hfffff >> (20 - BITS[i]);
         p0 = 20'h9c3a5 + 20'(i);
         p1 = 20'h36c5a - 20'(i);
         usr.set(0, 1'b1, 1'b1, 16'h01e2, p0, 20'hfffff);
         usr.set(1, 1'b1, 1'b1, 16'h01e2, p1, 20'hfffff);
         usr.go();
         usr.set(2, 1'b1, 1'b0, 16'h01e2, 20'h0, 20'h0);
         usr.set(3, 1'b1, 1'b0, 16'h01e2, 20'h0, 20'h0);
         repeat (2) usr.go();
         chk("half0 word", 80'(rd[2] & m), 80'(p0 & m));
         chk("half1 word", 80'(rd[3] & m), 80'(p1 & m));
      end
   endtask
   // simple mode, half then whole; port B data lines fill the upper 40 bits of the row that port A writes
   task automatic simple_dual_port_mode();
      for (int h = 0; h < 2; h++) begin
         mode(h[0], 1'b1, 4, 4'h0);
         put(0, 1'b1, 1'b1, 16'h0100, D1, ALL);
         put(2, 1'b0, 1'b1, 16'h0100, D2, ALL);
         usr.go();
         put(2, 1'b1, 1'b1, 16'h0100, 40'h0, ALL);
         repeat (2) usr.go();
         chk("simple word", {rd[3], rd[2], rd[1], rd[0]}, {D2, D1});
      end
   endtask
   initial begin
      mode(1'b1, 1'b0, 5, 4'h0);
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      @(negedge sys_clk);
      tdpWhole();
      tdpSplit();
      simple_dual_port_mode();
      conclude();
   end
endmodule
`default_nettype wire
